/* File: verilog/gpio_cf_defines.vh */
/*
 Constants for the port C to F register block: I/O and data-space
 offsets, address windows and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef GPIO_CF_DEFINES_VH
`define GPIO_CF_DEFINES_VH

// Direct I/O window limits
`define GPCF_IO_LOW 8'h00
`define GPCF_IO_HIGH 8'h3F
// Data-space displacement of the I/O window
`define GPCF_DS_IO_BASE 8'h20
// First extended I/O address
`define GPCF_EXT_BASE 8'h60

// I/O offsets (data-space address is offset plus displacement)
`define GPCF_OFS_PF_PIN 8'h00
`define GPCF_OFS_PE_PIN 8'h01
`define GPCF_OFS_PE_DIR 8'h02
`define GPCF_OFS_PE_OUT 8'h03
`define GPCF_OFS_PD_PIN 8'h10
`define GPCF_OFS_PD_DIR 8'h11
`define GPCF_OFS_PD_OUT 8'h12
`define GPCF_OFS_PC_PIN 8'h13
// Extended space addresses (data space only)
`define GPCF_ADR_PF_DIR 8'h61
`define GPCF_ADR_PF_OUT 8'h62

// Reset values, then all-zero and all-one words
`define GPCF_RST_OUT 8'h00
`define GPCF_RST_DIR 8'h00
`define GPCF_ZERO 8'h00
`define GPCF_ONES 8'hFF

`endif

/* File: verilog/gpcf_sync.v */
/*
 Two-stage synchroniser for an eight-bit pin group.
 Assumes pins are asynchronous to clk; no reset so it only follows pins.
*/
`timescale 1ns/10ps
module gpcf_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        stage1 <= pin_in;
        stage2 <= stage1;
    end

    assign pin_sync = stage2;
endmodule // gpcf_sync

/* File: verilog/gpcf_ports.v */
/*
 General-purpose I/O registers for port C (pin levels only), D, E, F.
 Register map, I/O offsets (data space adds 0x20): 0x00 port F pins,
 0x01 port E pins, 0x02 port E direction, 0x03 port E latch,
 0x10 port D pins, 0x11 port D direction, 0x12 port D latch,
 0x13 port C pins; data space only: 0x61 port F direction,
 0x62 port F latch.
 Assumes the core presents an 8-bit address with io_sel high for the
 direct I/O instructions and low for data-space load/store, a one-cycle
 read or write strobe, and takes read data combinationally.
 Assumes legacy_mode is a static strap that only changes while resetn
 is low, and global_pullup_disable comes from a register on clk.
 Assumes WIDTH matches the 8-bit data bus; pins are asynchronous to clk
 and reach the register file only through the synchronisers below.
 Assumes pad drivers outside this block honour out, oe and pullup.
 Assumes an unmapped read returning zero is harmless to the core,
 and that no other block answers the same addresses.
*/
`timescale 1ns/10ps
module gpcf_ports #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire resetn,
    input wire legacy_mode,
    input wire global_pullup_disable,
    input wire [7:0] bus_addr,
    input wire io_sel,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata,
    output wire bus_hit,
    input wire [WIDTH-1:0] port_c_in,
    output wire [WIDTH-1:0] port_c_out,
    output wire [WIDTH-1:0] port_c_oe,
    input wire [WIDTH-1:0] port_d_in,
    output wire [WIDTH-1:0] port_d_out,
    output wire [WIDTH-1:0] port_d_oe,
    output wire [WIDTH-1:0] port_d_pullup,
    input wire [WIDTH-1:0] port_e_in,
    output wire [WIDTH-1:0] port_e_out,
    output wire [WIDTH-1:0] port_e_oe,
    output wire [WIDTH-1:0] port_e_pullup,
    input wire [WIDTH-1:0] port_f_in,
    output wire [WIDTH-1:0] port_f_out,
    output wire [WIDTH-1:0] port_f_oe,
    output wire [WIDTH-1:0] port_f_pullup
);
`include "gpio_cf_defines.vh"

    // Writable registers
    reg [WIDTH-1:0] port_d_output_latch;
    reg [WIDTH-1:0] port_d_direction;
    reg [WIDTH-1:0] port_e_output_latch;
    reg [WIDTH-1:0] port_e_direction;
    reg [WIDTH-1:0] port_f_output_latch;
    reg [WIDTH-1:0] port_f_direction;
    // Pin levels after the synchronisers
    wire [WIDTH-1:0] port_c_pin_levels;
    wire [WIDTH-1:0] port_d_pin_levels;
    wire [WIDTH-1:0] port_e_pin_levels;
    wire [WIDTH-1:0] port_f_pin_levels;
    // Address decode
    wire [7:0] io_ofs;
    wire io_low_ok;
    wire ds_low_ok;
    wire low_ok;
    wire ext_ok;
    wire rd_live;
    // Register hits
    wire hit_pf_pin;
    wire hit_pe_pin;
    wire hit_pe_dir;
    wire hit_pe_out;
    wire hit_pd_pin;
    wire hit_pd_dir;
    wire hit_pd_out;
    wire hit_pc_pin;
    wire hit_pf_dir;
    wire hit_pf_out;
    // Write strobes
    wire wr_pd_out;
    wire wr_pd_dir;
    wire wr_pe_out;
    wire wr_pe_dir;
    wire wr_pf_out;
    wire wr_pf_dir;
    // Port F registers as the pads see them
    wire [WIDTH-1:0] f_lat_live;
    wire [WIDTH-1:0] f_dir_live;

    // All-zero and all-one pin words
    localparam [WIDTH-1:0] ALL_OFF = {WIDTH{1'b0}};
    localparam [WIDTH-1:0] ALL_ON = {WIDTH{1'b1}};

    // Pull-up is on for an input pin whose latch bit is one while dis is low
    function [WIDTH-1:0] pullup_of;
        input [WIDTH-1:0] dir;
        input [WIDTH-1:0] lat;
        input dis;
        begin
            pullup_of = dis ? {WIDTH{1'b0}} : (~dir & lat);
        end
    endfunction

    // Register match inside the low I/O window
    function low_hit;
        input ok;
        input [7:0] ofs;
        input [7:0] target;
        begin
            low_hit = ok && (ofs == target);
        end
    endfunction

    // Register match inside the extended window, absent in legacy mode
    function ext_hit;
        input ok;
        input legacy;
        input [7:0] addr;
        input [7:0] target;
        begin
            ext_hit = ok && !legacy && (addr == target);
        end
    endfunction

    // Pin synchronisers, one per port
    // Port C pins
    gpcf_sync #(.WIDTH(WIDTH)) u_sync_c (
        .clk(clk),
        .pin_in(port_c_in),
        .pin_sync(port_c_pin_levels)
    );

    // Port D pins
    gpcf_sync #(.WIDTH(WIDTH)) u_sync_d (
        .clk(clk),
        .pin_in(port_d_in),
        .pin_sync(port_d_pin_levels)
    );

    // Port E pins
    gpcf_sync #(.WIDTH(WIDTH)) u_sync_e (
        .clk(clk),
        .pin_in(port_e_in),
        .pin_sync(port_e_pin_levels)
    );

    // Port F pins
    gpcf_sync #(.WIDTH(WIDTH)) u_sync_f (
        .clk(clk),
        .pin_in(port_f_in),
        .pin_sync(port_f_pin_levels)
    );

    // I/O offset from either access form
    assign io_ofs = io_sel ? bus_addr : (bus_addr - `GPCF_DS_IO_BASE);
    // Direct I/O reaches only 0x00-0x3F
    assign io_low_ok = io_sel && (bus_addr <= `GPCF_IO_HIGH);
    // Data space reaches the low registers at 0x20-0x5F
    assign ds_low_ok = !io_sel && (bus_addr >= `GPCF_DS_IO_BASE) &&
        (bus_addr < `GPCF_EXT_BASE);
    // Low window from either access form
    assign low_ok = io_low_ok || ds_low_ok;
    // Extended window is data space only
    assign ext_ok = !io_sel && (bus_addr >= `GPCF_EXT_BASE);

    // Register decode
    assign hit_pf_pin = low_hit(low_ok, io_ofs, `GPCF_OFS_PF_PIN);
    assign hit_pe_pin = low_hit(low_ok, io_ofs, `GPCF_OFS_PE_PIN);
    assign hit_pe_dir = low_hit(low_ok, io_ofs, `GPCF_OFS_PE_DIR);
    assign hit_pe_out = low_hit(low_ok, io_ofs, `GPCF_OFS_PE_OUT);
    assign hit_pd_pin = low_hit(low_ok, io_ofs, `GPCF_OFS_PD_PIN);
    assign hit_pd_dir = low_hit(low_ok, io_ofs, `GPCF_OFS_PD_DIR);
    assign hit_pd_out = low_hit(low_ok, io_ofs, `GPCF_OFS_PD_OUT);
    assign hit_pc_pin = low_hit(low_ok, io_ofs, `GPCF_OFS_PC_PIN);
    // Port F output and direction vanish in legacy mode
    assign hit_pf_dir = ext_hit(ext_ok, legacy_mode, bus_addr,
        `GPCF_ADR_PF_DIR);
    assign hit_pf_out = ext_hit(ext_ok, legacy_mode, bus_addr,
        `GPCF_ADR_PF_OUT);

    assign bus_hit = hit_pf_pin | hit_pe_pin | hit_pe_dir | hit_pe_out |
        hit_pd_pin | hit_pd_dir | hit_pd_out | hit_pc_pin |
        hit_pf_dir | hit_pf_out;
    // Read data only while a read strobe meets a mapped register
    assign rd_live = bus_rd && bus_hit;

    // Write strobes; pin level registers get none, so writes drop
    assign wr_pd_out = bus_wr && hit_pd_out;
    assign wr_pd_dir = bus_wr && hit_pd_dir;
    assign wr_pe_out = bus_wr && hit_pe_out;
    assign wr_pe_dir = bus_wr && hit_pe_dir;
    assign wr_pf_out = bus_wr && hit_pf_out;
    assign wr_pf_dir = bus_wr && hit_pf_dir;

    // Port D registers
    always @(posedge clk) begin
        if (!resetn) begin
            port_d_output_latch <= `GPCF_RST_OUT;
            port_d_direction <= `GPCF_RST_DIR;
        end else begin
            if (wr_pd_out) begin
                port_d_output_latch <= bus_wdata;
            end
            if (wr_pd_dir) begin
                port_d_direction <= bus_wdata;
            end
        end
    end

    // Port E registers
    always @(posedge clk) begin
        if (!resetn) begin
            port_e_output_latch <= `GPCF_RST_OUT;
            port_e_direction <= `GPCF_RST_DIR;
        end else begin
            if (wr_pe_out) begin
                port_e_output_latch <= bus_wdata;
            end
            if (wr_pe_dir) begin
                port_e_direction <= bus_wdata;
            end
        end
    end

    // Port F registers; unreachable in legacy mode
    always @(posedge clk) begin
        if (!resetn) begin
            port_f_output_latch <= `GPCF_RST_OUT;
            port_f_direction <= `GPCF_RST_DIR;
        end else begin
            if (wr_pf_out) begin
                port_f_output_latch <= bus_wdata;
            end
            if (wr_pf_dir) begin
                port_f_direction <= bus_wdata;
            end
        end
    end

    // Pin level values have no reset; they follow the pins two edges late
    // Read multiplexer; unmapped or idle reads give zero
    always @* begin
        bus_rdata = `GPCF_ZERO;
        if (rd_live) begin
            if (hit_pf_pin) begin
                bus_rdata = port_f_pin_levels;
            end else if (hit_pe_pin) begin
                bus_rdata = port_e_pin_levels;
            end else if (hit_pe_dir) begin
                bus_rdata = port_e_direction;
            end else if (hit_pe_out) begin
                bus_rdata = port_e_output_latch;
            end else if (hit_pd_pin) begin
                bus_rdata = port_d_pin_levels;
            end else if (hit_pd_dir) begin
                bus_rdata = port_d_direction;
            end else if (hit_pd_out) begin
                bus_rdata = port_d_output_latch;
            end else if (hit_pc_pin) begin
                bus_rdata = port_c_pin_levels;
            end else if (hit_pf_dir) begin
                bus_rdata = port_f_direction;
            end else if (hit_pf_out) begin
                bus_rdata = port_f_output_latch;
            end
        end
    end

    // Port C pads: combinational so legacy state needs no clock edge;
    // outside legacy mode port C is input only and its pins just listen
    assign port_c_out = ALL_OFF;
    assign port_c_oe = legacy_mode ? ALL_ON : ALL_OFF;

    // Port D pad control
    assign port_d_out = port_d_output_latch;
    assign port_d_oe = port_d_direction;
    assign port_d_pullup = pullup_of(port_d_direction, port_d_output_latch,
        global_pullup_disable);

    // Port E pad control
    assign port_e_out = port_e_output_latch;
    assign port_e_oe = port_e_direction;
    assign port_e_pullup = pullup_of(port_e_direction, port_e_output_latch,
        global_pullup_disable);

    // Port F registers are blanked in legacy mode so the pins only listen
    assign f_lat_live = legacy_mode ? ALL_OFF : port_f_output_latch;
    assign f_dir_live = legacy_mode ? ALL_OFF : port_f_direction;

    // Port F pad control
    assign port_f_out = f_lat_live;
    assign port_f_oe = f_dir_live;
    assign port_f_pullup = pullup_of(f_dir_live, f_lat_live,
        global_pullup_disable);
endmodule // gpcf_ports

/* File: dv/gpcf_pins.sv */
/* Pin model for one eight-bit port of gpcf_ports.
 Assumes the bench drives ext_val where ext_en is high. */
`timescale 1ns/10ps
module gpcf_pins (
    input wire clk,
    input wire [7:0] out,
    input wire [7:0] oe,
    input wire [7:0] pu_en,
    input wire [7:0] ext_val,
    input wire [7:0] ext_en,
    output wire [7:0] level
);
    reg [7:0] drift = 8'h55;
    // A floating pin never holds a steady level
    always @(posedge clk) begin
        drift <= ~drift;
    end
    // Port drive wins, then outside drive, then pull-up, else drift
    assign level = (oe & out) | (~oe & ext_en & ext_val) |
        (~oe & ~ext_en & (pu_en | drift));
endmodule // gpcf_pins

/* File: dv/gpcf_ports_chk.sv */
/* Port-level checker for gpcf_ports.
 Assumes binding to every gpcf_ports instance. */
`timescale 1ns/10ps
module gpcf_chk #(parameter WIDTH = 8) (
    input wire clk, input wire resetn, input wire legacy_mode,
    input wire global_pullup_disable, input wire [7:0] bus_addr,
    input wire io_sel, input wire bus_wr, input wire bus_rd,
    input wire [7:0] bus_wdata, input wire [7:0] bus_rdata,
    input wire bus_hit, input wire [WIDTH-1:0] port_c_out,
    input wire [WIDTH-1:0] port_c_oe, input wire [WIDTH-1:0] port_d_in,
    input wire [WIDTH-1:0] port_d_out, input wire [WIDTH-1:0] port_d_oe,
    input wire [WIDTH-1:0] port_d_pullup, input wire [WIDTH-1:0] port_f_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_io_window: assert property
        (io_sel && bus_addr > 8'h3F |-> !bus_hit) else $error("io hit");
    a_ds_offset: assert property
        (!io_sel && bus_rd && bus_addr == 8'h32 |-> bus_rdata == port_d_out)
        else $error("ds read");
    a_ext_refused: assert property
        (io_sel && bus_addr == 8'h61 |-> !bus_hit) else $error("ext hit");
    a_legacy_c: assert property
        (legacy_mode |-> port_c_oe == 8'hFF && port_c_out == 8'h00)
        else $error("legacy c");
    a_legacy_f: assert property
        (legacy_mode && bus_addr == 8'h61 |-> !bus_hit && port_f_oe == 8'h00)
        else $error("legacy f");
    a_latch_write: assert property
        (bus_wr && io_sel && bus_addr == 8'h12 |=> port_d_out == $past(bus_wdata))
        else $error("latch write");
    a_dir_write: assert property
        (bus_wr && !io_sel && bus_addr == 8'h31 |=> port_d_oe == $past(bus_wdata))
        else $error("dir write");
    a_pin_sync: assert property
        (io_sel && bus_rd && bus_addr == 8'h10 |-> bus_rdata == $past(port_d_in, 2))
        else $error("pin sync");
    a_pullup_off: assert property
        (global_pullup_disable |-> port_d_pullup == 8'h00)
        else $error("pullup not off");
    a_pullup_on: assert property
        (!global_pullup_disable |-> port_d_pullup == (~port_d_oe & port_d_out))
        else $error("pullup");
    c_d_write: cover property (bus_wr && io_sel && bus_addr == 8'h12);
    c_legacy: cover property (legacy_mode);
    c_pud: cover property (global_pullup_disable && port_d_oe != 8'hFF);
endmodule // gpcf_chk
bind gpcf_ports gpcf_chk #(.WIDTH(WIDTH)) u_gpcf_chk (.clk, .resetn,
    .legacy_mode, .global_pullup_disable, .bus_addr, .io_sel, .bus_wr,
    .bus_rd, .bus_wdata, .bus_rdata, .bus_hit, .port_c_out, .port_c_oe,
    .port_d_in, .port_d_out, .port_d_oe, .port_d_pullup, .port_f_oe);

/* File: dv/testbench.sv */
/* Register-level bench for gpcf_ports with pin models on each port.
 Assumes one-cycle core strobes and combinational read data. */
`timescale 1ns/10ps
module testbench;
    reg clk = 1'b0, run = 1'b1, resetn = 1'b0, legacy_mode = 1'b0;
    reg global_pullup_disable = 1'b0, io_sel = 1'b0;
    reg bus_wr = 1'b0, bus_rd = 1'b0;
    reg [7:0] bus_addr = 8'h00, bus_wdata = 8'h00;
    reg [7:0] ext_val = 8'h00, ext_en = 8'h00;
    integer miscompares = 0, num_checks = 0;
    wire [7:0] bus_rdata, port_c_in, port_c_out, port_c_oe, port_d_in;
    wire [7:0] port_d_out, port_d_oe, port_d_pullup, port_e_in, port_e_out;
    wire [7:0] port_e_oe, port_e_pullup, port_f_in, port_f_out, port_f_oe;
    wire [7:0] port_f_pullup;
    wire bus_hit;
    gpcf_ports u_gpcf_ports (.clk, .resetn, .legacy_mode,
        .global_pullup_disable, .bus_addr, .io_sel, .bus_wr, .bus_rd,
        .bus_wdata, .bus_rdata, .bus_hit, .port_c_in, .port_c_out,
        .port_c_oe, .port_d_in, .port_d_out, .port_d_oe, .port_d_pullup,
        .port_e_in, .port_e_out, .port_e_oe, .port_e_pullup, .port_f_in,
        .port_f_out, .port_f_oe, .port_f_pullup);
    gpcf_pins u_gpcf_pins_c (.clk, .out(port_c_out), .oe(port_c_oe),
        .pu_en(8'h00), .ext_val, .ext_en, .level(port_c_in));
    gpcf_pins u_gpcf_pins_d (.clk, .out(port_d_out), .oe(port_d_oe),
        .pu_en(port_d_pullup), .ext_val, .ext_en, .level(port_d_in));
    gpcf_pins u_gpcf_pins_e (.clk, .out(port_e_out), .oe(port_e_oe),
        .pu_en(port_e_pullup), .ext_val, .ext_en, .level(port_e_in));
    gpcf_pins u_gpcf_pins_f (.clk, .out(port_f_out), .oe(port_f_oe),
        .pu_en(port_f_pullup), .ext_val, .ext_en, .level(port_f_in));
    // Clock, can be frozen to show the legacy strap acting without edges
    initial forever #20 if (run) clk = ~clk;
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input io, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            io_sel <= io;
            bus_addr <= a;
            bus_wdata <= d;
            bus_wr <= 1'b1;
            @(posedge clk);
            bus_wr <= 1'b0;
        end
    endtask
    task rd(input io, input [7:0] a, input [7:0] exp, input hit);
        begin
            @(posedge clk);
            io_sel <= io;
            bus_addr <= a;
            bus_rd <= 1'b1;
            @(negedge clk);
            chk(bus_rdata, exp);
            chk({7'h00, bus_hit}, {7'h00, hit});
            @(posedge clk);
            bus_rd <= 1'b0;
        end
    endtask
    // Write then read back through the given address
    task wrrd(input io, input [7:0] a, input [7:0] d, input [7:0] ra);
        begin
            wr(io, a, d);
            rd(1'b0, ra, d, 1'b1);
        end
    endtask
    task complete_run;
        begin
            if (miscompares == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        #100000;
        miscompares = miscompares + 1;
        complete_run;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(1'b1, 8'h12, 8'h00, 1'b1);
        rd(1'b1, 8'h11, 8'h00, 1'b1);
        rd(1'b1, 8'h03, 8'h00, 1'b1);
        rd(1'b1, 8'h02, 8'h00, 1'b1);
        rd(1'b0, 8'h62, 8'h00, 1'b1);
        rd(1'b0, 8'h61, 8'h00, 1'b1);
        wrrd(1'b1, 8'h12, 8'hA5, 8'h32);
        wrrd(1'b0, 8'h31, 8'h5A, 8'h31);
        wrrd(1'b1, 8'h03, 8'h3C, 8'h23);
        wrrd(1'b1, 8'h02, 8'hC3, 8'h22);
        wrrd(1'b0, 8'h62, 8'h96, 8'h62);
        wrrd(1'b0, 8'h61, 8'h69, 8'h61);
        chk(port_d_out, 8'hA5);
        chk(port_d_oe, 8'h5A);
        chk(port_e_out, 8'h3C);
        chk(port_e_oe, 8'hC3);
        wr(1'b1, 8'h61, 8'hFF);
        rd(1'b0, 8'h61, 8'h69, 1'b1);
        rd(1'b1, 8'h61, 8'h00, 1'b0);
        rd(1'b1, 8'h52, 8'h00, 1'b0);
        rd(1'b0, 8'h12, 8'h00, 1'b0);
        ext_en <= 8'hFF;
        ext_val <= 8'hF0;
        wr(1'b1, 8'h10, 8'hFF);
        rd(1'b1, 8'h10, 8'hA0, 1'b1);
        rd(1'b0, 8'h21, 8'h30, 1'b1);
        rd(1'b0, 8'h20, 8'h90, 1'b1);
        rd(1'b1, 8'h13, 8'hF0, 1'b1);
        ext_en <= 8'h00;
        repeat (3) @(posedge clk);
        rd(1'b1, 8'h10, 8'hA5, 1'b1);
        rd(1'b1, 8'h01, 8'h3C, 1'b1);
        chk(port_f_pullup, 8'h96);
        global_pullup_disable <= 1'b1;
        @(negedge clk);
        chk(port_d_pullup | port_e_pullup | port_f_pullup, 8'h00);
        // Legacy strap applied with the clock frozen
        @(posedge clk);
        run = 1'b0;
        resetn <= 1'b0;
        legacy_mode <= 1'b1;
        global_pullup_disable <= 1'b0;
        #200;
        chk(port_c_oe, 8'hFF);
        chk(port_c_out, 8'h00);
        run = 1'b1;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(port_d_out | port_d_oe, 8'h00);
        wr(1'b0, 8'h62, 8'hFF);
        rd(1'b0, 8'h62, 8'h00, 1'b0);
        rd(1'b0, 8'h61, 8'h00, 1'b0);
        chk(port_f_out | port_f_oe, 8'h00);
        complete_run;
    end
endmodule // testbench
